/* lsf_pkg.sv */
// Constants and types shared by the light sensor level filter
package lsf_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] LSF_SENS1_CFG_OFS = 8'h31;  // light_sensor1_config
  localparam logic [7:0] LSF_SENS2_CFG_OFS = 8'h32;  // light_sensor2_config

  // ----------------------------------------
  // Field positions of a sensor config
  // ----------------------------------------
  localparam int LSF_MEASUREMENT_FILTER_COUNT_LSB = 3;   // measurement_filter_count [5:3]
  localparam int LSF_MEASUREMENT_FILTER_COUNT_MSB = 5;
  localparam int LSF_FORCE_BIT = 2;  // Self-clearing forced conversion
  localparam int LSF_DARK_EN_BIT = 1;    // dark_level_enable
  localparam int LSF_OFFICE_EN_BIT = 0;  // office_level_enable

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [5:0] LSF_CFG_RST = 6'h00;  // Filter 1, comparators off
  localparam logic [7:0] LSF_CNT_RST = 8'h00;
  localparam logic [7:0] LSF_RDATA_RST = 8'h00;

  // Encoded light level, dark dominates office
  localparam logic [1:0] LSF_LVL_OUTDOOR = 2'h1;
  localparam logic [1:0] LSF_LVL_OFFICE = 2'h2;
  localparam logic [1:0] LSF_LVL_DARK = 2'h3;

  // Sensor sequencer states, one-hot
  typedef enum logic [2:0] {
    LSF_ST_RUN = 3'b001,    // Filtered periodic measurements
    LSF_ST_FWAIT = 3'b010,  // Forced conversion in flight
    LSF_ST_FDONE = 3'b100   // Flags updated, release force bit
  } lsf_state_t;

  // Debounce state of one level comparator
  typedef struct packed {
    logic flag;       // Decided level flag
    logic pend;       // Pending new state
    logic [7:0] cnt;  // Consecutive agreeing results
  } lsf_lvl_t;

endpackage

/* lsf_sensor.sv */
// One light sensor: hysteresis comparators, debounce filter, forced conversion
`timescale 1ns/100ps
module lsf_sensor
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Configuration
  input wire logic [2:0] measurement_filter_count_i,
  input wire logic force_i,
  input wire logic dark_en_i,
  input wire logic office_en_i,
  // Thresholds
  input wire logic [7:0] office_trip_i,
  input wire logic [7:0] office_hys_i,
  input wire logic [7:0] dark_trip_i,
  input wire logic [7:0] dark_hys_i,
  // Front end measurement
  input wire logic [7:0] meas_i,
  input wire logic meas_valid_i,
  output logic conv_req_o,
  // Results
  output logic force_done_o,
  output logic office_flag_o,
  output logic dark_flag_o,
  output logic [1:0] level_o
);
  import lsf_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Comparator verdict with hysteresis; between the bounds it holds
  function automatic logic lsf_target(input logic cur, input logic [7:0] m,
                                      input logic [7:0] trip, input logic [7:0] hys);
    logic [8:0] upper;
    upper = {1'b0, trip} + {1'b0, hys};  // Nine bits, no wrap
    if ({1'b0, m} < {1'b0, trip})
      lsf_target = 1'b1;
    else if ({1'b0, m} > upper)
      lsf_target = 1'b0;
    else
      lsf_target = cur;
  endfunction

  // One filter step for a level on a new measurement
  function automatic lsf_lvl_t lsf_step(input lsf_lvl_t s, input logic tgt,
                                        input logic [2:0] measurement_filter_count);
    lsf_lvl_t r;
    logic [8:0] need;
    logic [8:0] run;
    r = s;
    need = 9'h001 << measurement_filter_count;  // 2^n agreeing measurements
    run = {1'b0, s.cnt} + 9'h001;
    if (tgt == s.flag)
    begin
      r.cnt = LSF_CNT_RST;  // Agrees with current flag, nothing pending
    end
    else if ((tgt != s.pend) || (s.cnt == LSF_CNT_RST))
    begin
      // Disagreeing run broken: restart with this result
      r.pend = tgt;
      r.cnt = 8'h01;
      if (need == 9'h001)
      begin
        r.flag = tgt;
        r.cnt = LSF_CNT_RST;
      end
    end
    else if (run >= need)
    begin
      r.flag = tgt;  // Uninterrupted run complete
      r.cnt = LSF_CNT_RST;
    end
    else
    begin
      r.cnt = run[7:0];
    end
    lsf_step = r;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    lsf_state_t st;
    lsf_lvl_t office;
    lsf_lvl_t dark;
  } lsf_sens_t;

  lsf_sens_t s_q;  // Registered state
  lsf_sens_t s_d;  // Next state

  // Sequencer and filters
  always_comb
  begin
    s_d = s_q;
    case (s_q.st)
      LSF_ST_RUN:
      begin
        if (force_i)
          s_d.st = LSF_ST_FWAIT;  // Software asked for a conversion
        else if (meas_valid_i)
        begin
          s_d.office = lsf_step(s_q.office, lsf_target(s_q.office.flag, meas_i,
                                office_trip_i, office_hys_i), measurement_filter_count_i);
          s_d.dark = lsf_step(s_q.dark, lsf_target(s_q.dark.flag, meas_i,
                              dark_trip_i, dark_hys_i), measurement_filter_count_i);
        end
      end
      LSF_ST_FWAIT:
      begin
        // Forced result goes straight to the flags, pending runs dropped
        if (meas_valid_i)
        begin
          s_d.office.flag = lsf_target(s_q.office.flag, meas_i, office_trip_i,
                                       office_hys_i);
          s_d.dark.flag = lsf_target(s_q.dark.flag, meas_i, dark_trip_i,
                                     dark_hys_i);
          s_d.office.cnt = LSF_CNT_RST;
          s_d.dark.cnt = LSF_CNT_RST;
          s_d.st = LSF_ST_FDONE;
        end
      end
      LSF_ST_FDONE:
        s_d.st = LSF_ST_RUN;  // Flags already updated, bit released
      default:
        s_d.st = LSF_ST_RUN;
    endcase
    // Disabled comparator holds no flag and no run
    if (!office_en_i)
      s_d.office = '0;
    if (!dark_en_i)
      s_d.dark = '0;
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      s_q.st <= LSF_ST_RUN;
      s_q.office <= '0;
      s_q.dark <= '0;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign conv_req_o = (s_q.st == LSF_ST_FWAIT);
  assign force_done_o = (s_q.st == LSF_ST_FDONE);
  assign office_flag_o = s_q.office.flag;
  assign dark_flag_o = s_q.dark.flag;
  // Dark decision overrides office
  assign level_o = s_q.dark.flag ? LSF_LVL_DARK :
                   (s_q.office.flag ? LSF_LVL_OFFICE : LSF_LVL_OUTDOOR);

endmodule

/* lsf_top.sv */
// Dual light sensor level filter with its two configuration registers
`timescale 1ns/100ps
module lsf_top
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Sensor 1 thresholds
  input wire logic [7:0] s1_office_trip_i,
  input wire logic [7:0] s1_office_hys_i,
  input wire logic [7:0] s1_dark_trip_i,
  input wire logic [7:0] s1_dark_hys_i,
  // Sensor 1 front end
  input wire logic [7:0] s1_meas_i,
  input wire logic s1_meas_valid_i,
  output logic s1_conv_req_o,
  // Sensor 1 results
  output logic s1_office_flag_o,
  output logic s1_dark_flag_o,
  output logic [1:0] s1_level_o,
  // Sensor 2 thresholds
  input wire logic [7:0] s2_office_trip_i,
  input wire logic [7:0] s2_office_hys_i,
  input wire logic [7:0] s2_dark_trip_i,
  input wire logic [7:0] s2_dark_hys_i,
  // Sensor 2 front end
  input wire logic [7:0] s2_meas_i,
  input wire logic s2_meas_valid_i,
  output logic s2_conv_req_o,
  // Sensor 2 results
  output logic s2_office_flag_o,
  output logic s2_dark_flag_o,
  output logic [1:0] s2_level_o
);
  import lsf_pkg::*;

  // ----------------------------------------
  // Register layout
  // ----------------------------------------
  // Both sensor configs share one layout:
  //   [7:6] not stored, read back as zero
  //   [5:3] filter code, 2^code agreeing results needed
  //   [2]   forced conversion, cleared by hardware when done
  //   [1]   dark comparator enable
  //   [0]   office comparator enable
  // Only the force bit is ever changed by hardware; every other bit
  // keeps what software last wrote.
  // A write lands at its own edge; a read answers one cycle later
  // and the read data then stands until the next read strobe.
  // The trip and hysteresis values arrive as plain ports, since
  // their registers sit outside this block.

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  typedef struct packed {
    logic [5:0] cfg1;   // light_sensor1_config [5:0]
    logic [5:0] cfg2;   // light_sensor2_config [5:0]
    logic [7:0] rdata;  // Read data holding register
  } lsf_regs_t;

  lsf_regs_t r_q;  // Registered
  lsf_regs_t r_d;  // Next

  logic s1_done;  // Sensor 1 forced conversion finished
  logic s2_done;  // Sensor 2 forced conversion finished
  logic s1_wr;  // Write strobe aimed at sensor 1 config
  logic s2_wr;  // Write strobe aimed at sensor 2 config

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Apply a write and a hardware force clear; the write wins
  // The clear goes first, so a host write in the same cycle still lands
  // and a force request made just as the last one ends is not lost
  // Trade-off: a host cannot cancel a forced conversion in flight
  function automatic logic [5:0] lsf_cfg_next(input logic [5:0] cur, input logic wr,
                                              input logic [7:0] wd, input logic done);
    logic [5:0] n;
    n = cur;
    if (done)
      n[LSF_FORCE_BIT] = 1'b0;  // Self clear after update
    if (wr)
      n = wd[5:0];  // Bits 7:6 are not stored
    lsf_cfg_next = n;
  endfunction

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // Unmapped addresses match neither strobe, so such writes vanish
  assign s1_wr = reg_wr_i && (reg_addr_i == LSF_SENS1_CFG_OFS);
  assign s2_wr = reg_wr_i && (reg_addr_i == LSF_SENS2_CFG_OFS);

  // ----------------------------------------
  // Register write and read
  // ----------------------------------------
  // Decode and read mux
  always_comb
  begin
    // Default: every register holds
    r_d = r_q;
    // Two registers of one layout
    r_d.cfg1 = lsf_cfg_next(r_q.cfg1, s1_wr, reg_wdata_i, s1_done);
    r_d.cfg2 = lsf_cfg_next(r_q.cfg2, s2_wr, reg_wdata_i, s2_done);
    // Read data moves only on a strobe, so a slow host can fetch it later
    if (reg_rd_i)
    begin
      // Live force bit is visible, unused upper bits read zero
      case (reg_addr_i)
        // Sensor 1 config, upper bits padded
        LSF_SENS1_CFG_OFS:
          r_d.rdata = {2'h0, r_q.cfg1};
        // Sensor 2 config, upper bits padded
        LSF_SENS2_CFG_OFS:
          r_d.rdata = {2'h0, r_q.cfg2};
        // Every other address
        default:
          r_d.rdata = LSF_RDATA_RST;  // Unmapped address reads zero
      endcase
    end
  end

  // Register update
  // Reset leaves filter code 0 and both comparators off, so nothing
  // decides a level until software has written a config
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      // Synchronous reset, held for at least one edge
      r_q.cfg1 <= LSF_CFG_RST;
      r_q.cfg2 <= LSF_CFG_RST;
      r_q.rdata <= LSF_RDATA_RST;
    end
    else
      // Normal run: take the next value
      r_q <= r_d;
  end

  // ----------------------------------------
  // Register port outputs
  // ----------------------------------------
  // Straight from the holding flop, never from the live mux
  // Reads as zero after reset until the first read strobe
  assign reg_rdata_o = r_q.rdata;

  // ----------------------------------------
  // Sensors
  // ----------------------------------------
  // Both sensors use one module; only the config register, the threshold
  // set and the front end that feed them differ
  // Sensor 1 decision logic
  lsf_sensor u_sens1
  (
    // Clock and reset
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    // Config fields
    .measurement_filter_count_i(r_q.cfg1[LSF_MEASUREMENT_FILTER_COUNT_MSB:LSF_MEASUREMENT_FILTER_COUNT_LSB]),
    .force_i(r_q.cfg1[LSF_FORCE_BIT]),
    .dark_en_i(r_q.cfg1[LSF_DARK_EN_BIT]),
    .office_en_i(r_q.cfg1[LSF_OFFICE_EN_BIT]),
    // Thresholds
    .office_trip_i(s1_office_trip_i),
    .office_hys_i(s1_office_hys_i),
    .dark_trip_i(s1_dark_trip_i),
    .dark_hys_i(s1_dark_hys_i),
    // Front end
    .meas_i(s1_meas_i),
    .meas_valid_i(s1_meas_valid_i),
    .conv_req_o(s1_conv_req_o),
    // Results
    .force_done_o(s1_done),
    .office_flag_o(s1_office_flag_o),
    .dark_flag_o(s1_dark_flag_o),
    .level_o(s1_level_o)
  );

  // Sensor 2 decision logic
  lsf_sensor u_sens2
  (
    // Clock and reset
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    // Config fields
    .measurement_filter_count_i(r_q.cfg2[LSF_MEASUREMENT_FILTER_COUNT_MSB:LSF_MEASUREMENT_FILTER_COUNT_LSB]),
    .force_i(r_q.cfg2[LSF_FORCE_BIT]),
    .dark_en_i(r_q.cfg2[LSF_DARK_EN_BIT]),
    .office_en_i(r_q.cfg2[LSF_OFFICE_EN_BIT]),
    // Thresholds
    .office_trip_i(s2_office_trip_i),
    .office_hys_i(s2_office_hys_i),
    .dark_trip_i(s2_dark_trip_i),
    .dark_hys_i(s2_dark_hys_i),
    // Front end
    .meas_i(s2_meas_i),
    .meas_valid_i(s2_meas_valid_i),
    .conv_req_o(s2_conv_req_o),
    // Results
    .force_done_o(s2_done),
    .office_flag_o(s2_office_flag_o),
    .dark_flag_o(s2_dark_flag_o),
    .level_o(s2_level_o)
  );

endmodule

/* lsf_top_asserts.sv */
// Assertion checker for the light sensor level filter, sensor 1 and register port
`timescale 1ns/100ps
module lsf_top_asserts
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Sensor 1
  input wire logic s1_meas_valid_i,
  input wire logic s1_conv_req_o,
  input wire logic s1_office_flag_o,
  input wire logic s1_dark_flag_o,
  input wire logic [1:0] s1_level_o
);
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  AST_LVL_DARK: assert property (s1_dark_flag_o |-> s1_level_o == 2'h3)
    else $error("dark flag set but level not dark");
  AST_LVL_OFFICE: assert property (!s1_dark_flag_o && s1_office_flag_o
    |-> s1_level_o == 2'h2) else $error("office flag alone but level not office");
  AST_LVL_OUT: assert property (!s1_dark_flag_o && !s1_office_flag_o
    |-> s1_level_o == 2'h1) else $error("no flag but level not outdoor");
  // Flags move only after a result or a config write
  AST_OFFICE_CAUSE: assert property ($changed(s1_office_flag_o)
    |-> $past(s1_meas_valid_i) || $past(reg_wr_i) || $past(reg_wr_i, 2))
    else $error("office flag moved without cause");
  AST_DARK_CAUSE: assert property ($changed(s1_dark_flag_o) |-> $past(s1_meas_valid_i)
    || $past(reg_wr_i) || $past(reg_wr_i, 2)) else $error("dark flag moved without cause");
  AST_CONV_DROP: assert property (s1_conv_req_o && s1_meas_valid_i |=> !s1_conv_req_o)
    else $error("conversion request outlived its result");
  AST_CONV_START: assert property ($rose(s1_conv_req_o) |-> $past(reg_wr_i, 2)
    && $past(reg_wdata_i[2], 2) && $past(reg_addr_i, 2) == 8'h31) else $error("stray request");
  AST_RD_UNMAP: assert property (reg_rd_i && reg_addr_i != 8'h31 && reg_addr_i != 8'h32
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  AST_RD_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
endmodule

/* lsf_front_model.sv */
// Behavioural analog front end answering one light sensor
`timescale 1ns/100ps
module lsf_front_model
(
  // Clock and requests
  input wire logic clk_i,
  input wire logic conv_req_i,
  input wire logic go_i,
  // Value and answer delay
  input wire logic [7:0] val_i,
  input wire logic [3:0] dly_i,
  // Result
  output logic [7:0] meas_o,
  output logic meas_valid_o
);
  logic [3:0] wait_q = 4'h0; // Cycles spent on a forced request
  logic [7:0] last_q = 8'h00; // Last value handed over
  // Off a result the bus shows junk, so a stale value never passes for data
  always @(posedge clk_i)
  begin
    meas_valid_o <= 1'b0;
    meas_o <= ~last_q;
    if (go_i || (conv_req_i && !meas_valid_o && wait_q == dly_i))
    begin
      meas_valid_o <= 1'b1;
      meas_o <= val_i;
      last_q <= val_i;
      wait_q <= 4'h0;
    end
    else if (conv_req_i && !meas_valid_o)
      wait_q <= wait_q + 4'h1;
  end
endmodule

/* lsf_top_bench.sv */
// Self-checking bench for the light sensor level filter
`timescale 1ns/100ps
`define CMP(w, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; \
  $display("unexpected %s expected %h seen %h", w, e, s); end end
module lsf_top_bench;
  import lsf_pkg::*;
  logic clk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, rd_q = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, ev;
  logic [7:0] s1_office_trip_i = 8'h80, s1_office_hys_i = 8'h10;
  logic [7:0] s1_dark_trip_i = 8'h40, s1_dark_hys_i = 8'h10;
  logic [7:0] s2_office_trip_i = 8'h80, s2_office_hys_i = 8'h10;
  logic [7:0] s2_dark_trip_i = 8'h40, s2_dark_hys_i = 8'h10;
  logic [7:0] s1_meas_i, s2_meas_i, val [1:2];
  logic s1_meas_valid_i, s2_meas_valid_i, s1_conv_req_o, s2_conv_req_o, snap = 1'b0;
  logic s1_office_flag_o, s1_dark_flag_o, s2_office_flag_o, s2_dark_flag_o;
  logic [1:0] s1_level_o, s2_level_o, f [1:2];
  logic go [1:2];
  logic [7:0] exp_q [$];
  int fails = 0, num_checks = 0, n;
  wire [2:1] conv = {s2_conv_req_o, s1_conv_req_o};
  wire [7:0] obs = {s2_dark_flag_o, s2_office_flag_o, s2_level_o,
                    s1_dark_flag_o, s1_office_flag_o, s1_level_o};
  always #10 clk_i = ~clk_i;
  lsf_top u_lsf_top (.clk_i, .rst_b_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
    .reg_rdata_o, .s1_office_trip_i, .s1_office_hys_i, .s1_dark_trip_i, .s1_dark_hys_i,
    .s1_meas_i, .s1_meas_valid_i, .s1_conv_req_o, .s1_office_flag_o, .s1_dark_flag_o,
    .s1_level_o, .s2_office_trip_i, .s2_office_hys_i, .s2_dark_trip_i, .s2_dark_hys_i,
    .s2_meas_i, .s2_meas_valid_i, .s2_conv_req_o, .s2_office_flag_o, .s2_dark_flag_o,
    .s2_level_o);
  // Sensor 1 answers slowly, sensor 2 at once
  lsf_front_model u_fe1 (.clk_i, .conv_req_i(s1_conv_req_o), .go_i(go[1]), .val_i(val[1]),
    .dly_i(4'h3), .meas_o(s1_meas_i), .meas_valid_o(s1_meas_valid_i));
  lsf_front_model u_fe2 (.clk_i, .conv_req_i(s2_conv_req_o), .go_i(go[2]), .val_i(val[2]),
    .dly_i(4'h0), .meas_o(s2_meas_i), .meas_valid_o(s2_meas_valid_i));
  // Monitor: oldest note against read data or flags
  always @(posedge clk_i)
  begin
    rd_q <= reg_rd_i;
    if (rd_q || snap)
    begin
      ev = exp_q.pop_front();
      if (rd_q) `CMP("read data", ev, reg_rdata_o)
      else `CMP("level flags", ev, obs)
    end
  end
  function automatic logic [1:0] lv(input logic [1:0] d_o);
    return d_o[1] ? LSF_LVL_DARK : (d_o[0] ? LSF_LVL_OFFICE : LSF_LVL_OUTDOOR);
  endfunction
  task automatic chk();
    @(posedge clk_i);
    exp_q.push_back({f[2], lv(f[2]), f[1], lv(f[1])});
    snap <= 1'b1;
    @(posedge clk_i);
    snap <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    exp_q.push_back(e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
  endtask
  // Measurement: 0 dark, 1 bright, 2 inside dark hysteresis, 3 office only
  task automatic meas(input int s, input int k);
    logic [7:0] v;
    v = 8'(k == 0 ? $urandom_range(8'h3F, 8'h00) : k == 1 ? $urandom_range(8'hFF, 8'hA0)
      : k == 2 ? $urandom_range(8'h50, 8'h40) : $urandom_range(8'h7F, 8'h51));
    @(posedge clk_i);
    val[s] <= v;
    go[s] <= 1'b1;
    @(posedge clk_i);
    go[s] <= 1'b0;
  endtask
  task automatic end_of_test();
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(32'hd8b4a33a));
    f = '{2'b00, 2'b00};
    val = '{8'h00, 8'h00};
    go = '{1'b0, 1'b0};
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    rd(LSF_SENS1_CFG_OFS, 8'h00);
    wr(LSF_SENS1_CFG_OFS, 8'hCB);
    wr(LSF_SENS2_CFG_OFS, 8'h03);
    rd(LSF_SENS1_CFG_OFS, 8'h0B);
    rd(LSF_SENS2_CFG_OFS, 8'h03);
    meas(2, 0);
    f[2] = 2'b11;
    chk();
    meas(1, 0);
    meas(1, 1);
    meas(1, 0);
    chk();
    meas(1, 0);
    f[1] = 2'b11;
    chk();
    meas(1, 2);
    meas(1, 2);
    chk();
    meas(1, 3);
    meas(1, 3);
    f[1] = 2'b01;
    chk();
    for (int c = 0; c < 8; c++)
    begin
      wr(LSF_SENS2_CFG_OFS, {2'b00, c[2:0], 3'b011});
      repeat ((1 << c) - 1) meas(2, f[2][0]);
      chk();
      meas(2, f[2][0]);
      f[2] = ~f[2];
      chk();
    end
    wr(LSF_SENS1_CFG_OFS, 8'h08);
    f[1] = 2'b00;
    chk();
    wr(LSF_SENS1_CFG_OFS, 8'h0A);
    meas(1, 0);
    meas(1, 0);
    f[1] = 2'b10;
    chk();
    for (int s = 1; s < 3; s++)
    begin
      // Sensor 1 forced dark, sensor 2 forced bright, so the sensor 1 office flag and both sensor 2 flags must move
      val[s] <= (s == 1) ? 8'h10 : 8'hF0;
      wr(8'h30 + 8'(s), 8'h0F);
      n = 0;
      while (!conv[s] && n < 40) begin @(posedge clk_i); n++; end
      while (conv[s] && n < 40) begin @(posedge clk_i); n++; end
      `CMP("conversion wait", 1'b1, n < 40)
      f[s] = (s == 1) ? 2'b11 : 2'b00;
      chk();
      rd(8'h30 + 8'(s), 8'h0B);
    end
    repeat (4) @(posedge clk_i);
    end_of_test();
  end
endmodule
bind lsf_top lsf_top_asserts u_lsf_top_asserts (.clk_i, .rst_b_i, .reg_addr_i, .reg_wr_i,
  .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .s1_meas_valid_i, .s1_conv_req_o,
  .s1_office_flag_o, .s1_dark_flag_o, .s1_level_o);
